// >>> logic/burst_cfg_defs.vh
// constants for the burst read configuration byte and its read engine
// assumes inclusion by bare name from the logic/ folder
`ifndef BURST_CFG_DEFS_VH
`define BURST_CFG_DEFS_VH

`define CFG_RESET 8'h07
`define CFG_WRAP_RESET 3'h0
`define WRAP_ONCE_BIT 7
`define WRAP_SIZE_HI 6
`define WRAP_SIZE_LO 5
`define PROTECT_PIN_BIT 4
`define LATENCY_HI 3
`define LATENCY_LO 0
`define LATENCY_RESV_BIT 3

`define DUMMY_BASE 5'h08
`define DUMMY_MAX 5'h16
`define SPI_FIXED_DUMMY 5'h08
`define STATUS_DUMMY_SPI 5'h08
`define STATUS_DUMMY_OCTAL 5'h04

`define CMD_FAST_READ 8'h0B
`define CMD_OTP_READ 8'h77
`define CMD_WRAP_READ 8'h0C
`define CMD_STATUS_READ 8'h65
`define STATUS_ADDR_CFG 8'h03

`define LINE_MIN 7'h08

`endif

// >>> logic/burst_read_config_register.v
// burst read configuration byte with its dummy counter and read engine
// assumes a command decoder on sys_clk; sck, chip select and wp are pins
// Notes on behaviour
// - wrap mode sits in bit 7 and wrap length in bits 6..5 of the byte.
// - wrap settings are untouched by switching between spi and octal.
// - with wrap mode clear a wrap read cycles inside one line forever.
// - with wrap mode set the first line is read once, then the next line.
// - wrap length codes 0..3 give 8, 16, 32 and 64 byte lines.
// - power-up and the reset command give 8-byte continuous wrap, bits 000.
// - bit 4 reads 0 while write protect is asserted and 1 otherwise.
// - the protect bit is only meaningful in single-line spi mode.
// - in octal mode the programmable dummy count serves 0Bh, 77h and 0Ch.
// - dummy codes 0..7 give 8 to 22 cycles in steps of two; 8..15 reserved.
// - after power-up the dummy field is 7, i.e. 22 cycles.
// - dummy cycles are whole sck periods in sdr and ddr alike.
// - in spi mode fast-read dummy counts stay fixed.
// - status read 65h takes a register address, dummies, then msb first.
`timescale 1ns/1ps
`default_nettype none
`include "burst_cfg_defs.vh"

module burst_read_config_register #(
  parameter ADDR_W = 24,
  parameter [4:0] SPI_DUMMY = `SPI_FIXED_DUMMY
) (
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire sckPin,
  input wire chipSelectPin_n,
  input wire writeProtectPin_n,
  input wire octalMode,
  input wire ddrMode,
  input wire resetCmd,
  input wire cfgWrite,
  input wire [7:0] cfgWriteData,
  input wire readStart,
  input wire [7:0] readCmd,
  input wire [ADDR_W-1:0] readAddr,
  output wire [7:0] cfgReadData,
  output reg [4:0] dummyCycles,
  output wire busy,
  output reg dataPhase,
  output reg arrayStep,
  output wire [ADDR_W-1:0] arrayAddr,
  output reg [7:0] ioOut,
  output reg [7:0] ioOe_n
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DUMMY = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  localparam [7:0] CFG_RST = `CFG_RESET;

  // configuration fields
  reg wrapOnce_reg;
  reg [1:0] wrapSize_reg;
  reg [3:0] latency_reg;

  // synchronised pins
  wire [2:0] pinsSync;
  wire sckSync = pinsSync[0];
  wire csSync_n = pinsSync[1];
  wire wpSync_n = pinsSync[2];
  reg sckPrev_reg;
  wire sckRise = sckSync & ~sckPrev_reg;
  wire sckFall = ~sckSync & sckPrev_reg;

  // read engine
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] dummyCnt_reg;
  reg [4:0] dummyCnt_next;
  reg isStatus_reg;
  reg [7:0] statAddr_reg;
  reg [7:0] statAddr_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [2:0] bitCnt_reg;
  reg [2:0] bitCnt_next;
  reg octal_reg;
  reg ddr_reg;
  reg [4:0] dummyLoad;
  reg beat;

  pin_sync #(
    .WIDTH(3),
    // sck idles low, so no false edge leaves reset
    .INIT(3'b110)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .pinIn({writeProtectPin_n, chipSelectPin_n, sckPin}),
    .pinOut(pinsSync)
  );

  // commands that take the programmable dummy count
  function is_programmable;
    input [7:0] cmd;
    begin
      is_programmable = (cmd == `CMD_FAST_READ) || (cmd == `CMD_OTP_READ) ||
        (cmd == `CMD_WRAP_READ);
    end
  endfunction

  // status register byte selected by address
  function [7:0] status_byte;
    input [7:0] addr;
    input [7:0] cfgByte;
    begin
      status_byte = (addr == `STATUS_ADDR_CFG) ? cfgByte : 8'h00;
    end
  endfunction

  // dummy decode, reserved codes treated as longest
  function [4:0] latency_cycles;
    input [3:0] code;
    begin
      if (code[`LATENCY_RESV_BIT])
        latency_cycles = `DUMMY_MAX;
      else
        latency_cycles = `DUMMY_BASE + {1'b0, code[2:0], 1'b0};
    end
  endfunction

  // protect pin level in bit 4
  // pin level shown in any mode
  assign cfgReadData = {wrapOnce_reg, wrapSize_reg, wpSync_n, latency_reg};

  always @(posedge sys_clk) begin
    if (!resetn) begin
      wrapOnce_reg <= CFG_RST[`WRAP_ONCE_BIT];
      wrapSize_reg <= CFG_RST[`WRAP_SIZE_HI:`WRAP_SIZE_LO];
      latency_reg <= CFG_RST[`LATENCY_HI:`LATENCY_LO];
    end else if (clkEn) begin
      if (resetCmd) begin
        {wrapOnce_reg, wrapSize_reg} <= `CFG_WRAP_RESET;
      end else if (cfgWrite) begin
        wrapOnce_reg <= cfgWriteData[`WRAP_ONCE_BIT];
        wrapSize_reg <= cfgWriteData[`WRAP_SIZE_HI:`WRAP_SIZE_LO];
        latency_reg <= cfgWriteData[`LATENCY_HI:`LATENCY_LO];
      end
    end
  end

  // dummy count chosen at command start
  always @* begin
    if (readCmd == `CMD_STATUS_READ) begin
      dummyLoad = octalMode ? `STATUS_DUMMY_OCTAL : `STATUS_DUMMY_SPI;
    end else if (octalMode && is_programmable(readCmd)) begin
      dummyLoad = latency_cycles(latency_reg);
    end else begin
      dummyLoad = SPI_DUMMY;
    end
  end

  // data beats: octal ddr on both edges, else falling edge
  always @* begin
    if (ddr_reg && octal_reg)
      beat = sckRise | sckFall;
    else
      beat = sckFall;
  end

  always @* begin
    state_next = state_reg;
    dummyCnt_next = dummyCnt_reg;
    statAddr_next = statAddr_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    arrayStep = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (readStart) begin
          state_next = ST_DUMMY;
          dummyCnt_next = dummyLoad;
          statAddr_next = readAddr[7:0];
          bitCnt_next = 3'h0;
        end
      end
      ST_DUMMY: begin
        if (sckRise && dummyCnt_reg != 5'h00)
          dummyCnt_next = dummyCnt_reg - 5'h01;
        // first byte on the fall closing the last dummy
        if (sckFall && dummyCnt_reg == 5'h00) begin
          state_next = ST_DATA;
          shift_next = status_byte(statAddr_reg, cfgReadData);
        end
      end
      ST_DATA: begin
        if (beat) begin
          if (octal_reg) begin
            arrayStep = ~isStatus_reg;
            statAddr_next = statAddr_reg + 8'h01;
            shift_next = status_byte(statAddr_next, cfgReadData);
          end else begin
            bitCnt_next = bitCnt_reg + 3'h1;
            shift_next = {shift_reg[6:0], 1'b0};
            if (bitCnt_reg == 3'h7) begin
              arrayStep = ~isStatus_reg;
              statAddr_next = statAddr_reg + 8'h01;
              shift_next = status_byte(statAddr_next, cfgReadData);
            end
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (csSync_n && state_reg != ST_IDLE)
      state_next = ST_IDLE;
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      dummyCnt_reg <= 5'h00;
      statAddr_reg <= 8'h00;
      shift_reg <= 8'h00;
      bitCnt_reg <= 3'h0;
      sckPrev_reg <= 1'b0;
      isStatus_reg <= 1'b0;
      octal_reg <= 1'b0;
      ddr_reg <= 1'b0;
      dummyCycles <= 5'h00;
      dataPhase <= 1'b0;
    end else if (clkEn) begin
      sckPrev_reg <= sckSync;
      state_reg <= state_next;
      dummyCnt_reg <= dummyCnt_next;
      statAddr_reg <= statAddr_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      dataPhase <= (state_next == ST_DATA);
      if (state_reg == ST_IDLE && readStart) begin
        isStatus_reg <= (readCmd == `CMD_STATUS_READ);
        octal_reg <= octalMode;
        ddr_reg <= ddrMode;
        dummyCycles <= dummyLoad;
      end
    end
  end

  assign busy = (state_reg != ST_IDLE);

  // pin drive, enable low while driving
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ioOut <= 8'h00;
      ioOe_n <= 8'hFF;
    end else if (clkEn) begin
      if (state_next == ST_DATA && isStatus_reg) begin
        if (octal_reg) begin
          ioOut <= shift_next;
          ioOe_n <= 8'h00;
        end else begin
          ioOut <= {6'h00, shift_next[7], 1'b0};
          ioOe_n <= 8'hFD;
        end
      end else begin
        ioOut <= 8'h00;
        ioOe_n <= 8'hFF;
      end
    end
  end

  wrap_addr_gen #(
    .ADDR_W(ADDR_W)
  ) u_wrap_addr_gen (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .load(state_reg == ST_IDLE && readStart),
    .startAddr(readAddr),
    .step(arrayStep),
    .wrapEnable(readCmd == `CMD_WRAP_READ),
    .onceMode(wrapOnce_reg),
    .sizeSel(wrapSize_reg),
    .addr(arrayAddr)
  );

endmodule // burst_read_config_register

`default_nettype wire

// >>> logic/pin_sync.v
// two-stage synchroniser for pins arriving from outside the sys_clk domain
// assumes the inputs are plain levels; first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge sys_clk) begin
        if (!resetn) begin
          stage1_reg[i] <= INIT[i];
          stage2_reg[i] <= INIT[i];
        end else if (clkEn) begin
          stage1_reg[i] <= pinIn[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pinOut = stage2_reg;

endmodule // pin_sync

`default_nettype wire

// >>> logic/wrap_addr_gen.v
// byte address generator for linear and wrapping burst reads
// assumes load and step are single-cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "burst_cfg_defs.vh"

module wrap_addr_gen #(
  parameter ADDR_W = 24
) (
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire load,
  input wire [ADDR_W-1:0] startAddr,
  input wire step,
  input wire wrapEnable,
  input wire onceMode,
  input wire [1:0] sizeSel,
  output wire [ADDR_W-1:0] addr
);

  reg [ADDR_W-1:0] addr_reg;
  reg [ADDR_W-1:0] addr_next;
  reg [6:0] sent_reg;
  reg [6:0] sent_next;
  reg wrapActive_reg;
  reg wrapActive_next;
  reg once_reg;
  reg [1:0] size_reg;

  wire [6:0] lineLen = `LINE_MIN << size_reg;
  wire [6:0] lineMask = lineLen - 7'h01;
  wire [ADDR_W-1:0] maskFull = {{(ADDR_W-7){1'b0}}, lineMask};
  wire [ADDR_W-1:0] lenFull = {{(ADDR_W-7){1'b0}}, lineLen};
  wire [ADDR_W-1:0] linear = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] lineBase = addr_reg & ~maskFull;

  always @* begin
    addr_next = addr_reg;
    sent_next = sent_reg;
    wrapActive_next = wrapActive_reg;
    if (step) begin
      if (!wrapActive_reg) begin
        addr_next = linear;
      end else if (once_reg && sent_reg == lineMask) begin
        addr_next = lineBase + lenFull;
        wrapActive_next = 1'b0;
      end else begin
        addr_next = lineBase | (linear & maskFull);
        sent_next = sent_reg + 7'h01;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      addr_reg <= {ADDR_W{1'b0}};
      sent_reg <= 7'h00;
      wrapActive_reg <= 1'b0;
      once_reg <= 1'b0;
      size_reg <= 2'b00;
    end else if (clkEn) begin
      if (load) begin
        addr_reg <= startAddr;
        sent_reg <= 7'h00;
        wrapActive_reg <= wrapEnable;
        once_reg <= onceMode;
        size_reg <= sizeSel;
      end else begin
        addr_reg <= addr_next;
        sent_reg <= sent_next;
        wrapActive_reg <= wrapActive_next;
      end
    end
  end

  assign addr = addr_reg;

endmodule // wrap_addr_gen

`default_nettype wire

// >>> test/burst_cfg_checker.sv
// assertions on the config byte block ports
// assumes a bind onto the block
`timescale 1ns/1ps
`default_nettype none
module burst_cfg_checker #(
  parameter [4:0] SPI_DUMMY = 5'h08
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic writeProtectPin_n,
  input wire logic octalMode,
  input wire logic resetCmd,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgWriteData,
  input wire logic readStart,
  input wire logic [7:0] readCmd,
  input wire logic [7:0] cfgReadData,
  input wire logic [4:0] dummyCycles,
  input wire logic busy,
  input wire logic [7:0] ioOe_n
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic [4:0] progDummy;
  assign progDummy = cfgReadData[3] ? 5'h16 : 5'h08 + {cfgReadData[2:0], 1'b0};
  sequence s_take;
    clkEn && readStart && !busy;
  endsequence
  sequence s_prog;
    s_take ##0 (octalMode && readCmd inside {8'h0B, 8'h77, 8'h0C});
  endsequence
  a_wrap_write: assert property (clkEn && cfgWrite && !resetCmd |=>
    {cfgReadData[7:5], cfgReadData[3:0]} == $past({cfgWriteData[7:5], cfgWriteData[3:0]}))
    else $error("write not taken");
  a_reset_cmd: assert property (clkEn && resetCmd |=>
    cfgReadData[7:5] == 3'h0 && cfgReadData[3:0] == $past(cfgReadData[3:0]))
    else $error("reset command wrong");
  a_power_up: assert property ($rose(resetn) |->
    cfgReadData[7:5] == 3'h0 && cfgReadData[3:0] == 4'h7)
    else $error("reset value wrong");
  a_wrap_keep: assert property (!(clkEn && (cfgWrite || resetCmd)) |=>
    $stable(cfgReadData[7:5]))
    else $error("wrap bits changed");
  a_protect_pin: assert property ($past(clkEn) && $past(clkEn, 2) &&
    $past(resetn) && $past(resetn, 2) |-> cfgReadData[4] == $past(writeProtectPin_n, 2))
    else $error("protect bit wrong");
  a_prog_dummy: assert property (s_prog |=> dummyCycles == $past(progDummy))
    else $error("programmed dummy wrong");
  a_spi_fixed: assert property (s_take ##0 (!octalMode && readCmd != 8'h65) |=>
    dummyCycles == SPI_DUMMY)
    else $error("fixed dummy wrong");
  a_status_dummy: assert property (s_take ##0 (readCmd == 8'h65) |=>
    dummyCycles == ($past(octalMode) ? 5'h04 : 5'h08))
    else $error("status dummy wrong");
  a_idle_hiz: assert property (!busy && !$past(busy) |-> ioOe_n == 8'hFF)
    else $error("pins driven while idle");
endmodule // burst_cfg_checker
`default_nettype wire

// >>> test/host_sck_model.sv
// host side: chip select and serial clock
// assumes run is a level from the bench
`timescale 1ns/1ps
`default_nettype none
module host_sck_model #(
  parameter HALF_NS = 40,
  parameter LEAD_NS = 203
) (
  input wire logic run,
  output var logic sckPin,
  output var logic chipSelectPin_n,
  output var logic [7:0] sckCount
);
  initial begin
    sckPin = 1'b0;
    chipSelectPin_n = 1'b1;
    sckCount = 8'h00;
  end
  always @(posedge run) begin
    chipSelectPin_n = 1'b0;
    sckCount = 8'h00;
    #(LEAD_NS);
    while (run) begin
      sckPin = 1'b1;
      sckCount = sckCount + 8'h01;
      #(HALF_NS);
      sckPin = 1'b0;
      #(HALF_NS);
    end
    chipSelectPin_n = 1'b1;
  end
endmodule // host_sck_model
`default_nettype wire

// >>> test/test_burst_read_config_register.sv
// self-checking bench for the burst config byte
// assumes model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_burst_read_config_register;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic wpPin_n = 1'b1;
  logic octalMode = 1'b0;
  logic ddrMode = 1'b0;
  logic resetCmd = 1'b0;
  logic cfgWrite = 1'b0;
  logic [7:0] wData = 8'h00;
  logic readStart = 1'b0;
  logic [7:0] readCmd = 8'h00;
  logic [23:0] readAddr = 24'h00_0000;
  logic run = 1'b0;
  wire logic sckPin, csPin_n, busy, dataPhase, arrayStep;
  wire logic [7:0] cfgReadData, sckCount, ioOut, ioOe_n;
  wire logic [4:0] dummyCycles;
  wire logic [23:0] arrayAddr;
  int errorCnt = 0;
  int nChecks = 0;
  always #5 sys_clk = ~sys_clk;
  host_sck_model i_host_sck_model (.run(run), .sckPin(sckPin), .chipSelectPin_n(csPin_n),
    .sckCount(sckCount));
  burst_read_config_register i_burst_read_config_register (.sys_clk(sys_clk),
    .resetn(resetn), .clkEn(clkEn), .sckPin(sckPin), .chipSelectPin_n(csPin_n),
    .writeProtectPin_n(wpPin_n), .octalMode(octalMode), .ddrMode(ddrMode),
    .resetCmd(resetCmd), .cfgWrite(cfgWrite), .cfgWriteData(wData),
    .readStart(readStart), .readCmd(readCmd), .readAddr(readAddr),
    .cfgReadData(cfgReadData), .dummyCycles(dummyCycles), .busy(busy),
    .dataPhase(dataPhase), .arrayStep(arrayStep), .arrayAddr(arrayAddr),
    .ioOut(ioOut), .ioOe_n(ioOe_n));
  task automatic testDone;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic giveUp;
    errorCnt++;
    testDone();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic rc);
    @(posedge sys_clk);
    cfgWrite <= 1'b1;
    resetCmd <= rc;
    wData <= d;
    @(posedge sys_clk);
    cfgWrite <= 1'b0;
    resetCmd <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic start(input logic [7:0] c, input logic [23:0] a, input logic o, input logic d);
    @(posedge sys_clk);
    run <= 1'b1;
    octalMode <= o;
    ddrMode <= d;
    readCmd <= c;
    readAddr <= a;
    repeat (4) @(posedge sys_clk);
    readStart <= 1'b1;
    @(posedge sys_clk);
    readStart <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic stop;
    int i;
    @(posedge sys_clk);
    run <= 1'b0;
    for (i = 0; i < 60 && busy !== 1'b0; i++)
      @(negedge sys_clk);
    if (i == 60)
      giveUp();
  endtask
  task automatic waitDp;
    int i;
    for (i = 0; i < 400 && dataPhase !== 1'b1; i++)
      @(negedge sys_clk);
    if (i == 400)
      giveUp();
  endtask
  task automatic scReset;
    chk(cfgReadData, 8'h17);
    @(posedge sys_clk);
    wpPin_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(cfgReadData, 8'h07);
    @(posedge sys_clk);
    wpPin_n <= 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic scWrite;
    logic [3:0] i;
    for (i = 4'h0; i < 4'h9; i++) begin
      wr({i[2:0], 1'b0, i}, 1'b0);
      chk(cfgReadData, {i[2:0], 1'b1, i});
    end
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(8'h00, 1'b0);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    @(negedge sys_clk);
    chk(cfgReadData, 8'h18);
    wr(8'hE5, 1'b0);
    wr(8'hFF, 1'b1);
    chk(cfgReadData, 8'h15);
  endtask
  task automatic scDummy;
    logic [3:0] c;
    logic [23:0] cmds;
    int j;
    cmds = 24'h0B_770C;
    for (j = 0; j < 3; j++) begin
      for (c = 4'h0; c < 4'h9; c++) begin
        wr({4'h0, c}, 1'b0);
        start(cmds[j*8 +: 8], 24'h00_0000, 1'b1, 1'b0);
        chk(dummyCycles, c[3] ? 5'h16 : 5'h08 + {c[2:0], 1'b0});
        stop();
      end
    end
    start(8'h0B, 24'h00_0000, 1'b0, 1'b0);
    chk(dummyCycles, 5'h08);
    stop();
  endtask
  task automatic scStatus(input logic o);
    logic [7:0] b, n;
    int k, i;
    wr(8'hA3, 1'b0);
    start(8'h65, 24'h00_0003, o, 1'b0);
    waitDp();
    chk(sckCount, o ? 8'h04 : 8'h08);
    if (o) begin
      chk(ioOut, 8'hB3);
      chk(ioOe_n, 8'h00);
    end else begin
      for (k = 0; k < 8; k++) begin
        n = sckCount;
        for (i = 0; i < 40 && sckCount == n; i++)
          @(negedge sys_clk);
        if (i == 40)
          giveUp();
        b = {b[6:0], ioOut[1]};
      end
      chk(b, 8'hB3);
      chk(ioOe_n, 8'hFD);
    end
    stop();
    chk(ioOe_n, 8'hFF);
  endtask
  task automatic scWrap;
    logic [3:0] m;
    logic [23:0] a, len, base, e;
    int k, i;
    a = 24'h00_1235;
    for (m = 4'h0; m < 4'h8; m++) begin
      wr({m[2:0], 5'h00}, 1'b0);
      start(8'h0C, a, 1'b1, m[0]);
      waitDp();
      chk(sckCount, 8'h08);
      len = 24'h00_0008 << m[1:0];
      base = a & ~(len - 24'h00_0001);
      for (k = 0; k < len + 3; k++) begin
        for (i = 0; i < 40 && arrayStep !== 1'b1; i++)
          @(negedge sys_clk);
        if (i == 40)
          giveUp();
        e = (!m[2] || k < len) ? base + ((a + k) % len) : base + k;
        chk(arrayAddr, e);
        @(negedge sys_clk);
      end
      stop();
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(negedge sys_clk);
    scReset();
    scWrite();
    scDummy();
    scStatus(1'b1);
    scStatus(1'b0);
    scWrap();
    testDone();
  end
endmodule // test_burst_read_config_register
bind burst_read_config_register burst_cfg_checker #(.SPI_DUMMY(SPI_DUMMY)) i_burst_cfg_checker (
  .sys_clk, .resetn, .clkEn, .writeProtectPin_n, .octalMode, .resetCmd, .cfgWrite,
  .cfgWriteData, .readStart, .readCmd, .cfgReadData, .dummyCycles, .busy, .ioOe_n);
`default_nettype wire
